// >>> design/irq_group2_defines.vh
`ifndef IRQ_GROUP2_DEFINES_VH
`define IRQ_GROUP2_DEFINES_VH
// ==========================================
// register addresses on the special-function-register bus
`define IRQ_GROUP2_ENABLE_ADDR     8'hf3
`define IRQ_GROUP2_PRIO_LOW_ADDR   8'hed
`define IRQ_GROUP2_PRIO_HIGH_ADDR  8'hf6
// ==========================================
// register pages
`define IRQ_GROUP2_PAGE_BASE       8'h00
`define IRQ_GROUP2_PAGE_EXT        8'h10
// ==========================================
// reset values
`define IRQ_GROUP2_ENABLE_RST      8'h00
`define IRQ_GROUP2_PRIO_LOW_RST    8'h00
`define IRQ_GROUP2_PRIO_HIGH_RST   8'h00
// ==========================================
// bit positions, shared by the enable and priority registers
`define UART_B_BIT                 0
`define I2C_SLAVE_BIT              1
`define TIMER4_BIT                 2
`define TIMER5_BIT                 3
`define LOGIC_UNIT_BIT             4
`define SOURCE_COUNT               5
// ==========================================
// winner code when nothing is pending
`define IRQ_NONE_ID                3'h7
`endif

// >>> design/irq_prio_pick.v
`timescale 1ns/100ps
`default_nettype none
`include "irq_group2_defines.vh"
// ==========================================
// combinational pick of the highest priority pending source
module irq_prio_pick #(
  parameter N = 5
) (
  input  wire [N-1:0]   req_i,       // masked requests
  input  wire [N-1:0]   prio_low_i,  // priority low bits
  input  wire [N-1:0]   prio_high_i, // priority high bits
  output reg            any_o,       // some request pending
  output reg  [2:0]     id_o,        // winning source index
  output reg  [1:0]     level_o      // winning priority code
);
  integer k;
  always @* begin
    any_o   = 1'b0;
    id_o    = `IRQ_NONE_ID;
    level_o = 2'b00;
    // ties go to the lowest index, scanned from the top down
    for (k = N-1; k >= 0; k = k - 1) begin
      if (req_i[k] && (!any_o || {prio_high_i[k], prio_low_i[k]} >= level_o)) begin
        any_o   = 1'b1;
        id_o    = k[2:0];
        level_o = {prio_high_i[k], prio_low_i[k]};
      end
    end
  end
endmodule // irq_prio_pick
`default_nettype wire

// >>> design/irq_group2_enable_priority.v
// Contract
// - enable bit 2 passes timer 4 requests from either overflow flag, blocks them when clear.
// - enable bit 3 passes timer 5 requests from either overflow flag, blocks them when clear.
// - the logic unit priority takes bit 4 of the low and of the high priority register.
// - timer 5 priority takes bit 3 of the low and of the high priority register.
// - timer 4 priority takes bit 2 of the low and of the high priority register.
// - the I2C slave priority takes bit 1 of the low and of the high priority register.
// - the second UART priority takes bit 0 of the low and of the high priority register.
`timescale 1ns/100ps
`default_nettype none
`include "irq_group2_defines.vh"
module irq_group2_enable_priority (
  input  wire        mclk_i,                    // system clock
  input  wire        sys_rst_i,                 // async reset, high
  input  wire [7:0]  sfr_addr_i,                // register address
  input  wire [7:0]  sfr_page_i,                // register page
  input  wire        sfr_wr_i,                  // write strobe
  input  wire        sfr_rd_i,                  // read strobe
  input  wire [7:0]  sfr_wdata_i,               // write data
  input  wire        logic_unit_zero_req_i,     // logic unit request
  input  wire        timer4_low_overflow_flag_i,  // timer 4 low flag
  input  wire        timer4_high_overflow_flag_i, // timer 4 high flag
  input  wire        timer5_low_overflow_flag_i,  // timer 5 low flag
  input  wire        timer5_high_overflow_flag_i, // timer 5 high flag
  input  wire        i2c_slave_unit_req_i,      // i2c slave request
  input  wire        uart_b_req_i,              // second uart request
  output reg  [7:0]  sfr_rdata_o,               // read data
  output reg  [4:0]  irq_req_o,                 // masked requests
  output reg  [9:0]  irq_prio_o,                // 2-bit codes, source k at [2k+1:2k]
  output reg         irq_pending_o,             // any masked request
  output reg  [2:0]  irq_winner_o,              // winning source index
  output reg  [1:0]  irq_winner_level_o         // winning code
);
  reg  [7:0] irq_group2_enable;
  reg  [7:0] irq_group2_priority_low;
  reg  [7:0] irq_group2_priority_high;
  wire [4:0] raw_req;
  wire [4:0] masked_req;
  wire [4:0] prio_low;
  wire [4:0] prio_high;
  wire [9:0] next_prio;
  wire       pick_any;
  wire [2:0] pick_id;
  wire [1:0] pick_level;
  wire       hit_enable;
  wire       hit_prio_low;
  wire       hit_prio_high;
  // named enable bits
  wire       logic_unit_irq_enable;
  wire       timer5_irq_enable;
  wire       timer4_irq_enable;
  wire       i2c_slave_irq_enable;
  wire       uart_b_irq_enable;
  // named priority bits
  wire       logic_unit_prio_low;
  wire       logic_unit_prio_high;
  wire       timer5_prio_low;
  wire       timer5_prio_high;
  wire       timer4_prio_low;
  wire       timer4_prio_high;
  wire       i2c_slave_prio_low;
  wire       i2c_slave_prio_high;
  wire       uart_b_prio_low;
  wire       uart_b_prio_high;

  // ==========================================
  // address decode, shared by the write and the read path
  // enable answers on both pages so software need not switch page to mask
  function enable_hit;
    input [7:0] page;
    input [7:0] addr;
    begin
      enable_hit = (addr == `IRQ_GROUP2_ENABLE_ADDR) &&
                   ((page == `IRQ_GROUP2_PAGE_BASE) || (page == `IRQ_GROUP2_PAGE_EXT));
    end
  endfunction

  // priority registers exist on the extended page only
  function ext_hit;
    input [7:0] page;
    input [7:0] addr;
    input [7:0] target;
    begin
      ext_hit = (page == `IRQ_GROUP2_PAGE_EXT) && (addr == target);
    end
  endfunction

  assign hit_enable    = enable_hit(sfr_page_i, sfr_addr_i);
  assign hit_prio_low  = ext_hit(sfr_page_i, sfr_addr_i, `IRQ_GROUP2_PRIO_LOW_ADDR);
  assign hit_prio_high = ext_hit(sfr_page_i, sfr_addr_i, `IRQ_GROUP2_PRIO_HIGH_ADDR);

  // ==========================================
  // register access
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_group2_enable        <= `IRQ_GROUP2_ENABLE_RST;
      irq_group2_priority_low  <= `IRQ_GROUP2_PRIO_LOW_RST;
      irq_group2_priority_high <= `IRQ_GROUP2_PRIO_HIGH_RST;
    end else if (sfr_wr_i) begin
      if (hit_enable)
        irq_group2_enable <= sfr_wdata_i;
      if (hit_prio_low)
        irq_group2_priority_low <= sfr_wdata_i;
      if (hit_prio_high)
        irq_group2_priority_high <= sfr_wdata_i;
    end
  end

  // read data registered; unmapped reads return zero
  // a read in the cycle of a write to the same register sees the old value
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i) begin
      if (hit_enable)
        sfr_rdata_o <= irq_group2_enable;
      else if (hit_prio_low)
        sfr_rdata_o <= irq_group2_priority_low;
      else if (hit_prio_high)
        sfr_rdata_o <= irq_group2_priority_high;
      else
        sfr_rdata_o <= 8'h00;
    end
  end

  // ==========================================
  // enable bits; bits 7 to 5 steer nothing
  assign logic_unit_irq_enable = irq_group2_enable[`LOGIC_UNIT_BIT];
  assign timer5_irq_enable     = irq_group2_enable[`TIMER5_BIT];
  assign timer4_irq_enable     = irq_group2_enable[`TIMER4_BIT];
  assign i2c_slave_irq_enable  = irq_group2_enable[`I2C_SLAVE_BIT];
  assign uart_b_irq_enable     = irq_group2_enable[`UART_B_BIT];

  // ==========================================
  // masking
  // requests are levels from same-clock sources, so no edge capture here
  // either timer 4 flag
  assign raw_req[`TIMER4_BIT]     = timer4_low_overflow_flag_i | timer4_high_overflow_flag_i;
  assign raw_req[`TIMER5_BIT]     = timer5_low_overflow_flag_i | timer5_high_overflow_flag_i;
  assign raw_req[`LOGIC_UNIT_BIT] = logic_unit_zero_req_i;
  assign raw_req[`I2C_SLAVE_BIT]  = i2c_slave_unit_req_i;
  assign raw_req[`UART_B_BIT]     = uart_b_req_i;

  assign masked_req[`TIMER4_BIT]     = raw_req[`TIMER4_BIT] & timer4_irq_enable;
  assign masked_req[`TIMER5_BIT]     = raw_req[`TIMER5_BIT] & timer5_irq_enable;
  assign masked_req[`LOGIC_UNIT_BIT] = raw_req[`LOGIC_UNIT_BIT] & logic_unit_irq_enable;
  assign masked_req[`I2C_SLAVE_BIT]  = raw_req[`I2C_SLAVE_BIT] & i2c_slave_irq_enable;
  assign masked_req[`UART_B_BIT]     = raw_req[`UART_B_BIT] & uart_b_irq_enable;

  // ==========================================
  // priority fields
  // logic unit bit 4
  assign logic_unit_prio_low  = irq_group2_priority_low[`LOGIC_UNIT_BIT];
  assign logic_unit_prio_high = irq_group2_priority_high[`LOGIC_UNIT_BIT];
  assign timer5_prio_low      = irq_group2_priority_low[`TIMER5_BIT];
  assign timer5_prio_high     = irq_group2_priority_high[`TIMER5_BIT];
  assign timer4_prio_low      = irq_group2_priority_low[`TIMER4_BIT];
  assign timer4_prio_high     = irq_group2_priority_high[`TIMER4_BIT];
  assign i2c_slave_prio_low   = irq_group2_priority_low[`I2C_SLAVE_BIT];
  assign i2c_slave_prio_high  = irq_group2_priority_high[`I2C_SLAVE_BIT];
  assign uart_b_prio_low      = irq_group2_priority_low[`UART_B_BIT];
  assign uart_b_prio_high     = irq_group2_priority_high[`UART_B_BIT];

  // source order matches the enable bit positions
  assign prio_low  = {logic_unit_prio_low, timer5_prio_low, timer4_prio_low,
                      i2c_slave_prio_low, uart_b_prio_low};
  assign prio_high = {logic_unit_prio_high, timer5_prio_high, timer4_prio_high,
                      i2c_slave_prio_high, uart_b_prio_high};

  // pack each source's code as {high, low}
  genvar g;
  generate
    for (g = 0; g < `SOURCE_COUNT; g = g + 1) begin : g_pack
      assign next_prio[2*g+1:2*g] = {prio_high[g], prio_low[g]};
    end
  endgenerate

  irq_prio_pick #(
    .N (`SOURCE_COUNT)
  ) u_pick (
    .req_i       (masked_req),
    .prio_low_i  (prio_low),
    .prio_high_i (prio_high),
    .any_o       (pick_any),
    .id_o        (pick_id),
    .level_o     (pick_level)
  );

  // ==========================================
  // registered outputs to the arbitration; one cycle of latency
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_req_o          <= 5'h00;
      irq_prio_o         <= 10'h000;
      irq_pending_o      <= 1'b0;
      irq_winner_o       <= `IRQ_NONE_ID;
      irq_winner_level_o <= 2'b00;
    end else begin
      irq_req_o          <= masked_req;
      irq_prio_o         <= next_prio;
      irq_pending_o      <= pick_any;
      irq_winner_o       <= pick_id;
      irq_winner_level_o <= pick_level;
    end
  end
endmodule // irq_group2_enable_priority
`default_nettype wire

// >>> sim/periph_req_model.sv
`timescale 1ns/100ps
`default_nettype none
// ========
// peripheral request lines seen by the block
module periph_req_model (
  input  wire logic       mclk_i,  // system clock
  input  wire logic [6:0] level_i, // levels asked for by the bench
  output var  logic [6:0] req_o    // request lines to the block
);
  // flags change only at clock edges, as same-clock peripherals do
  always_ff @(posedge mclk_i) req_o <= level_i;
endmodule // periph_req_model
`default_nettype wire

// >>> sim/irq_group2_enable_priority_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "irq_group2_defines.vh"
// ========
// port checker
module irq_group2_checker (
  input wire logic       mclk_i, sys_rst_i, sfr_wr_i,
  input wire logic [7:0] sfr_addr_i, sfr_page_i, sfr_wdata_i,
  input wire logic       timer4_low_overflow_flag_i, timer4_high_overflow_flag_i,
  input wire logic       timer5_low_overflow_flag_i, timer5_high_overflow_flag_i,
  input wire logic [4:0] irq_req_o,
  input wire logic [9:0] irq_prio_o,
  input wire logic [1:0] irq_winner_level_o
);
  logic [7:0] en, pl, ph;
  logic [1:0] top;
  wire hi = sfr_page_i == `IRQ_GROUP2_PAGE_EXT;
  wire t4 = timer4_low_overflow_flag_i | timer4_high_overflow_flag_i;
  wire t5 = timer5_low_overflow_flag_i | timer5_high_overflow_flag_i;
  // shadow registers, so outputs can be tied to what software wrote
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) {en, pl, ph} <= 24'h00_0000;
    else if (sfr_wr_i) begin
      if (sfr_addr_i == `IRQ_GROUP2_ENABLE_ADDR && (hi || sfr_page_i == `IRQ_GROUP2_PAGE_BASE)) en <= sfr_wdata_i;
      if (hi && sfr_addr_i == `IRQ_GROUP2_PRIO_LOW_ADDR) pl <= sfr_wdata_i;
      if (hi && sfr_addr_i == `IRQ_GROUP2_PRIO_HIGH_ADDR) ph <= sfr_wdata_i;
    end
  end
  always_comb begin
    top = 2'h0;
    for (int k = 0; k < 5; k++) if (irq_req_o[k] && irq_prio_o[2*k+:2] > top) top = irq_prio_o[2*k+:2];
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  a_t4_mask: assert property (
    irq_req_o[2] == $past(en[2] & t4)) else $error("timer 4 request wrong");
  a_t5_mask: assert property (
    irq_req_o[3] == $past(en[3] & t5)) else $error("timer 5 request wrong");
  a_lu_prio: assert property (
    irq_prio_o[9:8] == $past({ph[4], pl[4]})) else $error("logic unit code wrong");
  a_t5_prio: assert property (
    irq_prio_o[7:6] == $past({ph[3], pl[3]})) else $error("timer 5 code wrong");
  a_t4_prio: assert property (
    irq_prio_o[5:4] == $past({ph[2], pl[2]})) else $error("timer 4 code wrong");
  a_i2c_prio: assert property (
    irq_prio_o[3:2] == $past({ph[1], pl[1]})) else $error("i2c code wrong");
  a_uart_prio: assert property (
    irq_prio_o[1:0] == $past({ph[0], pl[0]})) else $error("uart code wrong");
  a_winner_max: assert property (
    irq_winner_level_o == top) else $error("winner not highest");
endmodule // irq_group2_checker
bind irq_group2_enable_priority irq_group2_checker i_irq_group2_checker (.mclk_i, .sys_rst_i, .sfr_wr_i,
  .sfr_addr_i, .sfr_page_i, .sfr_wdata_i, .timer4_low_overflow_flag_i, .timer4_high_overflow_flag_i,
  .timer5_low_overflow_flag_i, .timer5_high_overflow_flag_i, .irq_req_o, .irq_prio_o, .irq_winner_level_o);
`default_nettype wire

// >>> sim/irq_group2_enable_priority_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "irq_group2_defines.vh"
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin n_fail++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module irq_group2_enable_priority_tb;
  localparam logic [7:0] pg0 = `IRQ_GROUP2_PAGE_BASE, pgx = `IRQ_GROUP2_PAGE_EXT, a_en = `IRQ_GROUP2_ENABLE_ADDR;
  localparam logic [7:0] a_pl = `IRQ_GROUP2_PRIO_LOW_ADDR, a_ph = `IRQ_GROUP2_PRIO_HIGH_ADDR;
  logic       mclk_i = 1'b0, sys_rst_i = 1'b1, wr = 1'b0, rd = 1'b0, pend;
  logic [7:0] addr = 8'h00, page = 8'h00, wdata = 8'h00, rdata;
  logic [6:0] level = 7'h00, rq;
  logic [4:0] req;
  logic [9:0] prio;
  logic [2:0] win;
  logic [1:0] wlev;
  int         n_fail = 0, checked = 0, cyc = 0, j;
  always #2 mclk_i = ~mclk_i;
  periph_req_model i_periph_req_model (.mclk_i(mclk_i), .level_i(level), .req_o(rq));
  irq_group2_enable_priority i_irq_group2_enable_priority (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .sfr_addr_i(addr), .sfr_page_i(page), .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wdata),
    .logic_unit_zero_req_i(rq[6]), .timer4_low_overflow_flag_i(rq[2]), .timer4_high_overflow_flag_i(rq[3]),
    .timer5_low_overflow_flag_i(rq[4]), .timer5_high_overflow_flag_i(rq[5]), .i2c_slave_unit_req_i(rq[1]),
    .uart_b_req_i(rq[0]), .sfr_rdata_o(rdata), .irq_req_o(req), .irq_prio_o(prio), .irq_pending_o(pend),
    .irq_winner_o(win), .irq_winner_level_o(wlev));
  task automatic close_out;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one strobe cycle; an idle edge first so a strobe is never dropped and raised in one step
  task automatic access(input logic w, input logic [7:0] p, a, d);
    @(posedge mclk_i);
    #1 {wr, rd, page, addr, wdata} = {w, !w, p, a, d};
    @(posedge mclk_i);
    #1 {wr, rd} = 2'b00;
  endtask
  task automatic rdc(input string n, input logic [7:0] p, a, e);
    access(1'b0, p, a, 8'h00);
    `CHK(n, e, rdata)
  endtask
  task automatic settle;
    repeat (3) @(posedge mclk_i);
    #1;
  endtask
  always @(posedge mclk_i) if (++cyc == 3000) begin n_fail++; close_out; end
  initial begin
    repeat (2) @(posedge mclk_i);
    #1 sys_rst_i = 1'b0;
    rdc("enable", pg0, a_en, 8'h00);
    rdc("prio low", pgx, a_pl, 8'h00);
    rdc("prio high", pgx, a_ph, 8'h00);
    for (int i = 0; i < 5; i++) begin
      j = (i + 1) % 5;
      access(1'b1, pgx, a_pl, 8'h01 << i);
      access(1'b1, pgx, a_ph, 8'h01 << j);
      settle;
      `CHK("codes", (10'h001 << 2*i) | (10'h002 << 2*j), prio)
      rdc("prio low", pgx, a_pl, 8'h01 << i);
    end
    access(1'b1, pg0, a_ph, 8'h1f);
    rdc("high after page 0 write", pgx, a_ph, 8'h01);
    rdc("low on page 0", pg0, a_pl, 8'h00);
    level = 7'h3c;
    settle;
    `CHK("disabled timers", 5'h00, req)
    access(1'b1, pg0, a_en, 8'h0c);
    for (int k = 2; k < 6; k++) begin
      level = 7'h01 << k;
      settle;
      `CHK("timer request", k < 4 ? 5'h04 : 5'h08, req)
    end
    access(1'b1, pgx, a_en, 8'h1f);
    level = 7'h7f;
    settle;
    `CHK("all requests", 5'h1f, req)
    `CHK("winner uart", {1'b1, 3'h0, 2'h2}, {pend, win, wlev})
    access(1'b1, pgx, a_pl, 8'h08);
    access(1'b1, pgx, a_ph, 8'h08);
    settle;
    `CHK("winner timer 5", {1'b1, 3'h3, 2'h3}, {pend, win, wlev})
    level = 7'h00;
    settle;
    `CHK("no winner", {1'b0, 3'h7, 2'h0}, {pend, win, wlev})
    close_out;
  end
endmodule // irq_group2_enable_priority_tb
`default_nettype wire
